// >>> rtl/tstc_pkg.sv
// Shared constants for the timer slave and external trigger control block
package tstc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] TIMER1_SMCR_ADDR = 32'h4000E008;
   localparam logic [31:0] TIMER2_SMCR_ADDR = 32'h4000F008;
   localparam logic [31:0] SMCR_RESET       = 32'h00000000;
   localparam logic [31:0] SMCR_WR_MASK     = 32'h0000FFF7;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ETP_BIT  = 15;
   localparam int ECE_BIT  = 14;
   localparam int ETPS_LSB = 12;
   localparam int ETF_LSB  = 8;
   localparam int MSM_BIT  = 7;
   localparam int TS_LSB   = 4;
   localparam int SMS_LSB  = 0;

   // ------------------------------------------------------------
   // Slave mode and trigger select codes
   // ------------------------------------------------------------
   localparam logic [2:0] SMS_OFF   = 3'h0;
   localparam logic [2:0] SMS_RESET = 3'h4;
   localparam logic [2:0] SMS_GATED = 3'h5;
   localparam logic [2:0] SMS_TRIG  = 3'h6;
   localparam logic [2:0] SMS_EXT1  = 3'h7;

   localparam logic [2:0] TS_INTERNAL_TRIGGER_ZERO   = 3'h0;
   localparam logic [2:0] TS_TI1ED  = 3'h4;
   localparam logic [2:0] TS_TI1    = 3'h5;
   localparam logic [2:0] TS_TI2    = 3'h6;
   localparam logic [2:0] TS_FILTERED_EXT_TRIGGER   = 3'h7;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   // Trigger-input delay, in core clock cycles, while master/slave sync is on
   localparam int MSM_DELAY_CYC = 1;

endpackage

// >>> rtl/tstc_ext_prescaler.sv
// External trigger prescaler: divides the rising-edge rate by 1, 2, 4 or 8
`timescale 1ns/1ps
module tstc_ext_prescaler
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   // Trigger path
   input  wire logic       sig_in,
   input  wire logic [1:0] prescale_in,
   output logic            sig_out
);

   typedef struct packed {
      logic       prev;
      logic [2:0] edges;
      logic       out;
   } tstc_pre_state_t;

   tstc_pre_state_t r;
   tstc_pre_state_t n;

   always_comb
   begin
      n = r;
      n.prev = sig_in;
      n.edges = r.edges + 3'(sig_in & ~r.prev);
      // Bit k of an edge counter rises once per 2^(k+1) input edges
      if (prescale_in == 2'h0)
         n.out = sig_in;
      else
         n.out = n.edges[prescale_in - 2'h1];
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= n;
   end

   assign sig_out = r.out;

   a_prescale_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (prescale_in == 2'h0) |=> (sig_out == $past(sig_in)))
      else $error("prescaler off does not pass trigger through");

endmodule

// >>> rtl/tstc_ext_filter.sv
// External trigger digital filter: sample-rate divider and agreement counter
`timescale 1ns/1ps
module tstc_ext_filter
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   // Trigger path
   input  wire logic       sig_in,
   input  wire logic [3:0] filter_in,
   output logic            sig_out
);

   typedef struct packed {
      logic [4:0] div;
      logic [3:0] agree;
      logic       out;
   } tstc_filt_state_t;

   tstc_filt_state_t r;
   tstc_filt_state_t n;
   logic [2:0]       rate_log;
   logic [3:0]       need;
   logic [4:0]       mask;
   logic             strobe;

   // Returns {log2 of sample divider, samples needed}
   function automatic logic [6:0] filt_decode(input logic [3:0] code);
      case (code)
         4'h0:    filt_decode = {3'h0, 4'h1};
         4'h1:    filt_decode = {3'h0, 4'h2};
         4'h2:    filt_decode = {3'h0, 4'h4};
         4'h3:    filt_decode = {3'h0, 4'h8};
         4'h4:    filt_decode = {3'h1, 4'h6};
         4'h5:    filt_decode = {3'h1, 4'h8};
         4'h6:    filt_decode = {3'h2, 4'h6};
         4'h7:    filt_decode = {3'h2, 4'h8};
         4'h8:    filt_decode = {3'h3, 4'h6};
         4'h9:    filt_decode = {3'h3, 4'h8};
         4'hA:    filt_decode = {3'h4, 4'h5};
         4'hB:    filt_decode = {3'h4, 4'h6};
         4'hC:    filt_decode = {3'h4, 4'h8};
         4'hD:    filt_decode = {3'h5, 4'h5};
         4'hE:    filt_decode = {3'h5, 4'h6};
         default: filt_decode = {3'h5, 4'h8};
      endcase
   endfunction

   always_comb
   begin
      {rate_log, need} = filt_decode(filter_in);
      mask = 5'((6'h01 << rate_log) - 6'h01);
      strobe = ((r.div & mask) == mask);
      n = r;
      n.div = r.div + 5'h01;
      if (filter_in == 4'h0)
      begin
         n.out = sig_in;
         n.agree = 4'h0;
      end
      else if (strobe)
      begin
         // A sample equal to the output restarts the count
         if (sig_in == r.out)
            n.agree = 4'h0;
         else if ((r.agree + 4'h1) >= need)
         begin
            n.out = sig_in;
            n.agree = 4'h0;
         end
         else
            n.agree = r.agree + 4'h1;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= n;
   end

   assign sig_out = r.out;

   a_filter_bypass: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (filter_in == 4'h0) |=> (sig_out == $past(sig_in)))
      else $error("filter code zero does not pass samples through");

   a_filter_needs_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (filter_in != 4'h0 && n.out != r.out) |-> (strobe && (r.agree + 4'h1) >= need))
      else $error("filter output changed without enough agreeing samples");

endmodule

// >>> rtl/tstc_slave_ctrl.sv
// Timer slave-mode and external trigger control with its control register
//
// Function
// - Polarity bit 15: 0 passes trigger pin, 1 inverts it before processing.
// - Bit 14 set: counter advances on each active filtered external trigger edge.
// - Clock mode 2 acts like clock mode 1 with filtered external trigger.
// - Clock mode 2 may combine with reset, gated, trigger; software avoids select 111.
// - Both external clock modes on: filtered external trigger clocks the counter.
// - Prescale field 13:12 divides trigger edge rate by 1, 2, 4 or 8.
// - Filter codes 0..3: full clock; no filter, then 2, 4, 8 samples.
// - Codes 4..9: clock divided by 2, 4, 8; 6 or 8 samples.
// - Codes 10..15: divided by 16 or 32; 5, 6, 8 samples.
// - Master/slave bit delays trigger input effect for exact step with slave.
// - Trigger select routes internal zero, edge detect, input 1, input 2, external.
// - Slave mode 000 uses internal clock; 111 counts trigger rising edges.
// - Mode 100 resets counter, 101 gates counting, 110 starts counter.
`timescale 1ns/1ps
module tstc_slave_ctrl
#(
   parameter logic [31:0] REG_ADDR      = tstc_pkg::TIMER1_SMCR_ADDR,
   parameter int          MSM_DELAY_CYC = tstc_pkg::MSM_DELAY_CYC
)
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // Register port
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   output logic      [31:0] rd_data_out,
   // Trigger sources
   input  wire logic        ext_trigger_pin_in,
   input  wire logic        internal_trigger_zero_in,
   input  wire logic        input1_edge_detect_in,
   input  wire logic        filtered_input1_in,
   input  wire logic        filtered_input2_in,
   // Counter core interface
   input  wire logic        counter_run_bit_in,
   output logic             count_tick_out,
   output logic             counter_reset_out,
   output logic             counter_start_out,
   output logic             count_gate_out,
   output logic             trigger_input_out,
   output logic             filtered_ext_trigger_out
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (MSM_DELAY_CYC < 1 || MSM_DELAY_CYC > 8)
      $error("MSM_DELAY_CYC must lie in 1..8");

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic                     etp;
      logic                     ece;
      logic [1:0]               etps;
      logic [3:0]               etf;
      logic                     msm;
      logic [2:0]               ts;
      logic [2:0]               sms;
      logic [MSM_DELAY_CYC-1:0] dly;
      logic                     trig_prev;
      logic                     filtered_ext_trigger_prev;
      logic [31:0]              rd_data;
      logic                     tick;
      logic                     rst_pulse;
      logic                     start_pulse;
      logic                     gate;
      logic                     trig;
      logic                     filtered_ext_trigger_q;
   } tstc_state_t;

   tstc_state_t r;
   tstc_state_t n;

   logic pol_trig;
   logic pre_trig;
   logic filtered_ext_trigger;
   logic trig_now;
   logic trig_lvl;
   logic trig_rise;
   logic filtered_ext_trigger_rise;
   logic ext_clk;
   logic src_edge;
   logic gate_ok;
   logic reg_hit;

   // ------------------------------------------------------------
   // External trigger path: polarity, prescaler, filter
   // ------------------------------------------------------------
   assign pol_trig = ext_trigger_pin_in ^ r.etp;

   tstc_ext_prescaler u_pre
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .sig_in      (pol_trig),
      .prescale_in (r.etps),
      .sig_out     (pre_trig)
   );

   tstc_ext_filter u_filt
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .sig_in      (pre_trig),
      .filter_in   (r.etf),
      .sig_out     (filtered_ext_trigger)
   );

   // ------------------------------------------------------------
   // Trigger selection
   // ------------------------------------------------------------
   function automatic logic trig_mux(input logic [2:0] sel,
                                     input logic       internal_trigger_zero,
                                     input logic       ti1ed,
                                     input logic       ti1,
                                     input logic       ti2,
                                     input logic       ext);
      case (sel)
         tstc_pkg::TS_INTERNAL_TRIGGER_ZERO:  trig_mux = internal_trigger_zero;
         tstc_pkg::TS_TI1ED: trig_mux = ti1ed;
         tstc_pkg::TS_TI1:   trig_mux = ti1;
         tstc_pkg::TS_TI2:   trig_mux = ti2;
         tstc_pkg::TS_FILTERED_EXT_TRIGGER:  trig_mux = ext;
         default:            trig_mux = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      n = r;
      reg_hit = (addr_in == REG_ADDR);
      // Unused codes fall to the default branch and stay low
      trig_now = trig_mux(r.ts, internal_trigger_zero_in, input1_edge_detect_in,
                          filtered_input1_in, filtered_input2_in, filtered_ext_trigger);
      // The delay line always shifts so the delayed copy is valid when sync turns on
      n.dly = MSM_DELAY_CYC'({r.dly, trig_now});
      trig_lvl = r.msm ? r.dly[MSM_DELAY_CYC-1] : trig_now;
      trig_rise = trig_lvl & ~r.trig_prev;
      filtered_ext_trigger_rise = filtered_ext_trigger & ~r.filtered_ext_trigger_prev;
      n.trig_prev = trig_lvl;
      n.filtered_ext_trigger_prev = filtered_ext_trigger;

      // Clock mode 2 overrides clock mode 1 source when both are set
      ext_clk = r.ece || (r.sms == tstc_pkg::SMS_EXT1);
      src_edge = r.ece ? filtered_ext_trigger_rise : trig_rise;
      gate_ok = (r.sms == tstc_pkg::SMS_GATED) ? trig_lvl : 1'b1;

      n.tick = counter_run_bit_in && (ext_clk ? src_edge : 1'b1) && gate_ok;
      n.rst_pulse = (r.sms == tstc_pkg::SMS_RESET) && trig_rise;
      n.start_pulse = (r.sms == tstc_pkg::SMS_TRIG) && trig_rise;
      n.gate = gate_ok;
      n.trig = trig_lvl;
      n.filtered_ext_trigger_q = filtered_ext_trigger;

      if (wr_en_in && reg_hit)
      begin
         // Reserved bits are simply never stored
         n.etp  = wr_data_in[tstc_pkg::ETP_BIT];
         n.ece  = wr_data_in[tstc_pkg::ECE_BIT];
         n.etps = wr_data_in[tstc_pkg::ETPS_LSB +: 2];
         n.etf  = wr_data_in[tstc_pkg::ETF_LSB +: 4];
         n.msm  = wr_data_in[tstc_pkg::MSM_BIT];
         n.ts   = wr_data_in[tstc_pkg::TS_LSB +: 3];
         n.sms  = wr_data_in[tstc_pkg::SMS_LSB +: 3];
      end

      n.rd_data = 32'h00000000;
      if (rd_en_in && reg_hit)
      begin
         n.rd_data[tstc_pkg::ETP_BIT]       = r.etp;
         n.rd_data[tstc_pkg::ECE_BIT]       = r.ece;
         n.rd_data[tstc_pkg::ETPS_LSB +: 2] = r.etps;
         n.rd_data[tstc_pkg::ETF_LSB +: 4]  = r.etf;
         n.rd_data[tstc_pkg::MSM_BIT]       = r.msm;
         n.rd_data[tstc_pkg::TS_LSB +: 3]   = r.ts;
         n.rd_data[tstc_pkg::SMS_LSB +: 3]  = r.sms;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= n;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rd_data_out              = r.rd_data;
   assign count_tick_out           = r.tick;
   assign counter_reset_out        = r.rst_pulse;
   assign counter_start_out        = r.start_pulse;
   assign count_gate_out           = r.gate;
   assign trigger_input_out        = r.trig;
   assign filtered_ext_trigger_out = r.filtered_ext_trigger_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_reserved_read_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      rd_en_in |=> (rd_data_out[31:16] == 16'h0000 && rd_data_out[3] == 1'b0))
      else $error("reserved register bits read non-zero");

   a_write_read_back: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_en_in && reg_hit) ##1 (rd_en_in && reg_hit)
      |=> (rd_data_out == ($past(wr_data_in, 2) & tstc_pkg::SMCR_WR_MASK)))
      else $error("register read back differs from masked write");

   a_ece_ext_edge: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r.ece && counter_run_bit_in && r.sms != tstc_pkg::SMS_GATED)
      |=> (count_tick_out == $past(filtered_ext_trigger_rise)))
      else $error("clock mode 2 tick does not follow external edge");

   a_ext1_trig_edge: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!r.ece && r.sms == tstc_pkg::SMS_EXT1 && counter_run_bit_in)
      |=> (count_tick_out == $past(trig_rise)))
      else $error("clock mode 1 tick does not follow trigger edge");

   a_internal_clock: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!r.ece && r.sms == tstc_pkg::SMS_OFF && counter_run_bit_in) |=> count_tick_out)
      else $error("disabled slave mode does not tick every cycle");

   a_reset_mode_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ##1 (counter_reset_out == $past(r.sms == tstc_pkg::SMS_RESET && trig_rise)))
      else $error("reset-mode pulse wrong");

   a_gated_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r.sms == tstc_pkg::SMS_GATED) |=> (count_gate_out == $past(trig_lvl)))
      else $error("gate does not follow trigger level");

   a_unused_select: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r.ts inside {3'h1, 3'h2, 3'h3}) |-> !trig_now)
      else $error("unused trigger select is not inactive");

   a_select_filtered_ext_trigger: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r.ts == tstc_pkg::TS_FILTERED_EXT_TRIGGER) |-> (trig_now == filtered_ext_trigger))
      else $error("external trigger select routes wrong source");

   a_msm_delay: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r.msm && $past(!rst_in, MSM_DELAY_CYC)) |-> (trig_lvl == $past(trig_now, MSM_DELAY_CYC)))
      else $error("master/slave delay not applied");

   c_reset_mode: cover property (@(posedge core_clk_in) disable iff (rst_in) counter_reset_out);
   c_start_mode: cover property (@(posedge core_clk_in) disable iff (rst_in) counter_start_out);
   c_ece_tick:   cover property (@(posedge core_clk_in) disable iff (rst_in)
      r.ece && count_tick_out);
   c_gated_stop: cover property (@(posedge core_clk_in) disable iff (rst_in)
      r.sms == tstc_pkg::SMS_GATED && !count_gate_out);

endmodule

// >>> verification/tstc_trig_src.sv
// Far-side model: external trigger pin source and peer timer trigger
`timescale 1ns/1ps
module tstc_trig_src
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   // Bench control
   input  wire logic       run_in,
   input  wire logic [3:0] half_in,
   input  wire logic       level_in,
   input  wire logic       peer_in,
   // Far-side outputs
   output logic            ext_trigger_pin_out,
   output logic            internal_trigger_zero_out
);
   logic [3:0] cnt_reg;
   logic [3:0] lim;

   // -----------------------------------------
   // Pin toggling
   // -----------------------------------------
   // A half period of two cycles or more keeps edges within a quarter of the core rate
   assign lim = (half_in < 4'h2) ? 4'h2 : half_in;
   assign internal_trigger_zero_out = peer_in;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || !run_in)
      begin
         cnt_reg             <= 4'h0;
         ext_trigger_pin_out <= rst_in ? 1'b0 : level_in;
      end
      else if (cnt_reg + 4'h1 >= lim)
      begin
         cnt_reg             <= 4'h0;
         ext_trigger_pin_out <= !ext_trigger_pin_out;
      end
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the timer slave and external trigger control
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] A = tstc_pkg::TIMER1_SMCR_ADDR;
   localparam int          D = tstc_pkg::MSM_DELAY_CYC;
   logic        clk, rst, wr_en, rd_en, run_bit, ti1ed, ti1, ti2;
   logic        p_run, p_lvl, peer, cnt_en, pin_d, pin, internal_trigger_zero;
   logic        tick, crst, cstart, gate, trig, filtered_ext_trigger;
   logic [3:0]  half;
   logic [2:0]  modes [5];
   logic [31:0] addr, wdata, rdata, d, v;
   int          fails, n_checks, seed, n_tick, n_rst, n_start, n_cyc, n_hi, n_edge, k, dv, nn;

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   tstc_slave_ctrl i_dut
   (
      .core_clk_in              (clk),
      .rst_in                   (rst),
      .addr_in                  (addr),
      .wr_data_in               (wdata),
      .wr_en_in                 (wr_en),
      .rd_en_in                 (rd_en),
      .rd_data_out              (rdata),
      .ext_trigger_pin_in       (pin),
      .internal_trigger_zero_in (internal_trigger_zero),
      .input1_edge_detect_in    (ti1ed),
      .filtered_input1_in       (ti1),
      .filtered_input2_in       (ti2),
      .counter_run_bit_in       (run_bit),
      .count_tick_out           (tick),
      .counter_reset_out        (crst),
      .counter_start_out        (cstart),
      .count_gate_out           (gate),
      .trigger_input_out        (trig),
      .filtered_ext_trigger_out (filtered_ext_trigger)
   );

   tstc_trig_src i_src
   (
      .core_clk_in               (clk),
      .rst_in                    (rst),
      .run_in                    (p_run),
      .half_in                   (half),
      .level_in                  (p_lvl),
      .peer_in                   (peer),
      .ext_trigger_pin_out       (pin),
      .internal_trigger_zero_out (internal_trigger_zero)
   );

   // -----------------------------------------
   // Event counting
   // -----------------------------------------
   always @(posedge clk)
   begin
      pin_d <= pin;
      if (pin === 1'b1 && pin_d === 1'b0)
         n_edge++;
      if (cnt_en)
      begin
         n_cyc++;
         n_tick  += int'(tick === 1'b1);
         n_rst   += int'(crst === 1'b1);
         n_start += int'(cstart === 1'b1);
         n_hi    += int'(filtered_ext_trigger !== 1'b0);
      end
   end

   // -----------------------------------------
   // Helpers
   // -----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic lost;
      fails++;
      $display("MISMATCH wait expected done seen timeout");
      wrap_up();
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] x);
      @(posedge clk);
      addr  <= a;
      wdata <= x;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 q = rdata;
   endtask

   function automatic logic [31:0] cf(input int p, e, s, f, m, t, sm);
      return {16'h0, p[0], e[0], s[1:0], f[3:0], m[0], t[2:0], 1'b0, sm[2:0]};
   endfunction

   function automatic int fdiv(input int c);
      return (c < 4) ? 1 : (c < 10) ? (2 << ((c - 4) / 2)) : (c < 13) ? 16 : 32;
   endfunction

   function automatic int fn(input int c);
      return (c == 0) ? 1 : (c < 4) ? (1 << c) : (c < 10) ? 6 + 2 * (c % 2)
             : (c % 3 == 1) ? 5 : (c % 3 == 2) ? 6 : 8;
   endfunction

   // Counts ticks over sixteen rising pin edges at a random legal rate
   task automatic run_ticks(input logic [31:0] c, input int exp);
      wr(A, c);
      half <= 4'h2 + 4'($random(seed) & 3);
      cyc(10);
      n_tick = 0;
      n_edge = 0;
      cnt_en = 1'b1;
      p_run <= 1'b1;
      for (k = 0; k < 500 && n_edge < 16; k++)
         @(posedge clk);
      p_run <= 1'b0;
      if (k == 500)
         lost();
      cyc(30);
      cnt_en = 1'b0;
      chk("ticks", n_tick, exp);
   endtask

   task automatic setsrc(input int t, input logic b);
      peer  <= (t == 0) ? b : !b;
      ti1ed <= (t == 4) ? b : !b;
      ti1   <= (t == 5) ? b : !b;
      ti2   <= (t == 6) ? b : !b;
      p_lvl <= (t == 7) ? b : !b;
   endtask

   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial
   begin
      {wr_en, rd_en, run_bit, ti1ed, ti1, ti2, p_run, p_lvl, peer, cnt_en, pin_d} = '0;
      {addr, wdata, half, fails, n_checks, n_tick, n_rst, n_start, n_cyc, n_hi, n_edge} = '0;
      modes = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
      seed = 37413;
      rst = 1'b1;
      cyc(8);
      rst <= 1'b0;
      rd(A, d);
      chk("reset", d, tstc_pkg::SMCR_RESET);
      for (int i = 0; i < 8; i++)
      begin
         v = $random(seed);
         wr(A, v);
         rd(A, d);
         chk("reg", d, v & tstc_pkg::SMCR_WR_MASK);
      end
      wr(tstc_pkg::TIMER2_SMCR_ADDR, 32'hFFFFFFFF);
      rd(tstc_pkg::TIMER2_SMCR_ADDR, d);
      chk("unmapped", d, 32'h00000000);
      rd(A, d);
      chk("kept", d, v & tstc_pkg::SMCR_WR_MASK);
      // Edge clocking with each prescale, both clock modes together, clock mode 1 alone, then run bit low
      run_bit <= 1'b1;
      for (int p = 0; p < 4; p++)
         run_ticks(cf(0, 1, p, 0, 0, 0, 0), 16 >> p);
      run_ticks(cf(0, 1, 0, 0, 0, 7, 7), 16);
      run_ticks(cf(0, 0, 0, 0, 0, 7, 7), 16);
      run_bit <= 1'b0;
      run_ticks(cf(0, 0, 0, 0, 0, 0, 0), 0);
      run_bit <= 1'b1;
      // Inverted pin: only a falling pin edge clocks
      run_ticks(cf(1, 1, 0, 0, 0, 0, 0), 16);
      #1 chk("filtered_ext_trigger_inv", filtered_ext_trigger, 1'b1);
      cnt_en = 1'b1;
      @(posedge clk);
      p_lvl <= 1'b1;
      cyc(10);
      cnt_en = 1'b0;
      #1 chk("rise_no_tick", n_tick, 16);
      chk("filtered_ext_trigger_inv", filtered_ext_trigger, 1'b0);
      // Every filter code: steady level passed in time; codes 1..15 also reject a short glitch
      for (int c = 0; c < 16; c++)
      begin
         dv = fdiv(c);
         nn = fn(c);
         @(posedge clk);
         p_lvl <= 1'b0;
         wr(A, cf(0, 0, 0, c, 0, 7, 0));
         cyc((nn + 2) * dv + 8);
         cnt_en = 1'b1;
         n_hi = 0;
         if (c != 0)
         begin
            p_lvl <= 1'b1;
            cyc((nn - 1) * dv);
            p_lvl <= 1'b0;
            cyc(nn * dv + 8);
         end
         cnt_en = 1'b0;
         chk("glitch", n_hi, 0);
         @(posedge clk);
         p_lvl <= 1'b1;
         for (k = 0; k < (nn + 1) * dv + 8 && filtered_ext_trigger !== 1'b1; k++)
            @(posedge clk) #1;
         chk("filter", (k >= (nn - 1) * dv) && (filtered_ext_trigger === 1'b1), 1);
      end
      // Trigger routing and sync delay; select changes only with slave mode off
      for (int m = 0; m < 2; m++)
         for (int t = 0; t < 8; t++)
            for (int b = 0; b < 2; b++)
            begin
               wr(A, cf(0, 0, 0, 0, m, t, 0));
               @(posedge clk);
               setsrc(t, !b);
               cyc(12);
               setsrc(t, b);
               for (k = 1; k <= 20; k++)
               begin
                  @(posedge clk) #1;
                  if (trig === ((t >= 1 && t <= 3) ? 1'b0 : 1'(b)))
                     break;
               end
               if (k > 20)
                  lost();
               if (t == 0 || t >= 4 && t <= 6)
                  chk("trig_lat", k, 1 + m * D);
               else
                  chk("trig_val", trig, (t == 7) ? 1'(b) : 1'b0);
            end
      // Slave modes on the peer trigger; gated mode never with the edge detector
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         peer <= 1'b0;
         wr(A, cf(0, 0, 0, 0, 0, 0, modes[i]));
         cyc(10);
         {n_tick, n_rst, n_start, n_cyc} = '0;
         cnt_en = 1'b1;
         peer <= 1'b1;
         cyc(10);
         #1 chk("gate_hi", gate, 1'b1);
         @(posedge clk);
         peer <= 1'b0;
         cyc(10);
         cnt_en = 1'b0;
         #1 chk("gate_lo", gate, modes[i] != 3'h5);
         chk("resets", n_rst, modes[i] == 3'h4);
         chk("starts", n_start, modes[i] == 3'h6);
         if (modes[i] == 3'h0)
            chk("int_ticks", n_tick, n_cyc);
         if (modes[i] == 3'h7)
            chk("ext1_ticks", n_tick, 1);
      end
      wrap_up();
   end
endmodule
